/* rphs_pkg.sv */
// Shared constants, types and CRC step for the radio packet sequencer
package rphs_pkg;

    // Framing bytes, then the CRC polynomial and initial value
    localparam logic [7:0]  PREAMBLE_BYTE   = 8'haa;
    localparam logic [7:0]  SYNC_FIRST      = 8'h2d;
    localparam logic [7:0]  SYNC_SECOND     = 8'hd4;
    localparam logic [15:0] CRC_POLY        = 16'h8005;
    localparam logic [15:0] CRC_INIT        = 16'hffff;

    // Field lengths in bytes, then button width in bits, FIFO depth in entries and LED count
    localparam logic [7:0]  LEGACY_PRE_LEN  = 8'h04;
    localparam logic [7:0]  STATUS_PRE_LEN  = 8'h0d;
    localparam logic [7:0]  VAR_PRE_LEN     = 8'h04;
    localparam logic [7:0]  SYNC_LEN        = 8'h02;
    localparam logic [7:0]  LEGACY_BODY_LEN = 8'h03;
    localparam logic [7:0]  STATUS_BODY_LEN = 8'h07;
    localparam logic [7:0]  VAR_BODY_LEN    = 8'h01;
    localparam logic [7:0]  CRC_LEN         = 8'h02;
    localparam int          BUTTON_BITS     = 5;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          LED_COUNT       = 4;

    // LED function codes
    localparam logic [1:0]  FN_KEEP         = 2'h0;
    localparam logic [1:0]  FN_OFF          = 2'h1;
    localparam logic [1:0]  FN_ON           = 2'h2;

    typedef enum logic [1:0] {
        PK_LEGACY = 2'b00,
        PK_STATUS = 2'b01,
        PK_VAR    = 2'b10
    } rphs_kind_t;

    // Transmit request, sampled on start
    typedef struct packed {
        rphs_kind_t  kind;
        logic [7:0]  cmd;
        logic [31:0] fob_id;
        logic [7:0]  status;
        logic [15:0] count;
        logic [7:0]  length;
    } rphs_tx_req_t;

    // Decoded key-fob status report
    typedef struct packed {
        logic [31:0]            fob_id;
        logic [BUTTON_BITS-1:0] buttons;
        logic [15:0]            count;
    } rphs_fob_rpt_t;

    // One byte through the CRC, msb first
    function automatic logic [15:0] rphs_crc_byte(input logic [15:0] c,
                                                  input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

endpackage

/* rphs_fifo.sv */
// Payload FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rphs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic                        ready;
    } rphs_fifo_state_t;

    rphs_fifo_state_t s, next_s;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////
    // Ready is registered so the source sees a flop, never a path
    always_comb begin
        next_s = s;
        push = in_valid_in && s.ready;
        pop  = out_ready_in && (s.cnt != '0);
        if (push) begin
            next_s.mem[s.wr] = in_data_in;
            next_s.wr = (s.wr == LAST_PTR) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == LAST_PTR) ? '0 : s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
        next_s.ready = (next_s.cnt != FULL_CNT);
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign in_ready_out  = s.ready;
    assign out_data_out  = s.mem[s.rd];
    assign out_valid_out = (s.cnt != '0);
endmodule // rphs_fifo

/* rphs_sequencer.sv */
// Packet framer and parser for the sub-GHz radio host side
//
// Contract
// - Legacy packet: 4 preamble, 2 sync, command, inverted command, command.
// - Command holds four 2-bit LED codes, output three in top pair.
// - Status packet: 13x 0xaa, 2d d4, id4, status, count2, crc2.
// - Four-byte identifier is unique per transmitter, used to tell them apart.
// - Button state is the low five bits of the status byte.
// - CRC-16 polynomial x16+x15+x2+1, register starts all ones.
// - Variable packet: 4-5 byte preamble, 16-bit sync, length, payload, CRC.
// - Length counts payload bytes; CRC covers length and payload.
// - After transmit completes, return to receive for the acknowledge.
`timescale 1ns/100ps
module rphs_sequencer
    import rphs_pkg::*;
#(
    parameter logic [7:0] VAR_PREAMBLE_BYTES = VAR_PRE_LEN,
    parameter int         PAY_DEPTH          = FIFO_DEPTH
) (
    input  wire logic                clock_in,
    input  wire logic                sys_rst_in,
    input  wire logic                ce_in,
    input  wire logic                tx_start_in,
    input  wire rphs_pkg::rphs_tx_req_t tx_req_in,
    output logic                     tx_busy_out,
    output logic                     tx_done_out,
    output logic                     rx_mode_out,
    input  wire logic [7:0]          pay_data_in,
    input  wire logic                pay_valid_in,
    output logic                     pay_ready_out,
    output logic [7:0]               tx_byte_out,
    output logic                     tx_valid_out,
    input  wire logic                tx_ready_in,
    input  wire logic                rx_start_in,
    input  wire rphs_pkg::rphs_kind_t rx_kind_in,
    input  wire logic [7:0]          rx_byte_in,
    input  wire logic                rx_valid_in,
    output logic                     cmd_ok_out,
    output logic                     fob_ok_out,
    output rphs_pkg::rphs_fob_rpt_t  fob_rpt_out,
    output logic                     var_ok_out,
    output logic [7:0]               rx_len_out,
    output logic [7:0]               rx_data_out,
    output logic                     rx_data_valid_out,
    output logic                     rx_err_out,
    output logic                     led_output_zero_out,
    output logic                     led_output_one_out,
    output logic                     led_output_two_out,
    output logic                     led_output_three_out
);
    import rphs_pkg::*;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE  = 3'b001,
        TX_SYNC = 3'b010,
        TX_BODY = 3'b011,
        TX_PAY  = 3'b100,
        TX_CRC  = 3'b101
    } rphs_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_HDR  = 2'b01,
        RX_PAY  = 2'b10,
        RX_CRC  = 2'b11
    } rphs_rx_st_t;

    typedef struct packed {
        rphs_tx_st_t          tx_st;
        logic [7:0]           tx_idx;
        rphs_tx_req_t         req;
        logic [15:0]          tx_crc;
        logic [7:0]           tx_byte;
        logic                 tx_valid;
        logic                 tx_done;
        logic                 busy;
        logic                 rx_mode;
        rphs_rx_st_t          rx_st;
        rphs_kind_t           rx_kind;
        logic [7:0]           rx_idx;
        logic [7:0]           rx_len;
        logic [15:0]          rx_crc;
        logic [7:0]           crc_hi;
        logic [55:0]          hdr;
        logic [LED_COUNT-1:0] leds;
        logic                 cmd_ok;
        logic                 fob_ok;
        logic                 var_ok;
        rphs_fob_rpt_t        rpt;
        logic [7:0]           rx_data;
        logic                 rx_data_valid;
        logic                 rx_err;
    } rphs_state_t;

    rphs_state_t s, next_s;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;
    logic        take;
    logic [7:0]  b;

    ////////////////////////////////////////////////////////////////////
    // Preamble length per format
    function automatic logic [7:0] pre_len(input rphs_kind_t k);
        return (k == PK_LEGACY) ? LEGACY_PRE_LEN
             : (k == PK_STATUS) ? STATUS_PRE_LEN : VAR_PREAMBLE_BYTES;
    endfunction

    // Body length after sync
    function automatic logic [7:0] body_len(input rphs_kind_t k);
        return (k == PK_LEGACY) ? LEGACY_BODY_LEN
             : (k == PK_STATUS) ? STATUS_BODY_LEN : VAR_BODY_LEN;
    endfunction

    // Body byte at an index; identifier and counter go msb first
    function automatic logic [7:0] body_byte(input rphs_tx_req_t r,
                                             input logic [7:0]   i);
        logic [55:0] f;
        f = {r.fob_id, r.status, r.count};
        case (r.kind)
            PK_LEGACY: return (i == 8'h01) ? ~r.cmd : r.cmd;
            PK_STATUS: return f[8*(6-i) +: 8];
            default:   return r.length;
        endcase
    endfunction

    // Apply four two-bit LED codes, output zero in the low pair
    function automatic logic [LED_COUNT-1:0] led_apply(
            input logic [LED_COUNT-1:0] cur, input logic [7:0] cmd);
        logic [LED_COUNT-1:0] r;
        r = cur;
        for (int i = 0; i < LED_COUNT; i++) begin
            if (cmd[2*i +: 2] inside {FN_ON, FN_OFF}) begin
                r[i] = (cmd[2*i +: 2] == FN_ON);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Payload buffer; its ready stalls the payload source
    rphs_fifo #(
        .WIDTH (8),
        .DEPTH (PAY_DEPTH)
    ) u_pay_fifo (
        .clock_in      (clock_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .in_data_in    (pay_data_in),
        .in_valid_in   (pay_valid_in),
        .in_ready_out  (pay_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for both the framer and the parser
    always_comb begin
        next_s = s;
        next_s.tx_done = 1'b0;
        next_s.cmd_ok = 1'b0;
        next_s.fob_ok = 1'b0;
        next_s.var_ok = 1'b0;
        next_s.rx_data_valid = 1'b0;
        next_s.rx_err = 1'b0;
        fifo_pop = 1'b0;
        b = rx_byte_in;
        // On ready, every busy state but a dry payload wait loads a byte
        take = !s.tx_valid || tx_ready_in;
        if (take) begin
            next_s.tx_valid = (s.tx_st != TX_IDLE) &&
                              (s.tx_st != TX_PAY || fifo_valid);
            next_s.tx_idx = s.tx_idx + 8'(next_s.tx_valid);
        end

        // Framer
        case (s.tx_st)
            TX_IDLE: begin
                if (tx_start_in) begin
                    next_s.req = tx_req_in;
                    next_s.tx_st = TX_PRE;
                    next_s.tx_idx = '0;
                    next_s.rx_mode = 1'b0;
                end
            end
            TX_PRE: begin
                if (take) begin
                    next_s.tx_byte = PREAMBLE_BYTE;
                    if (s.tx_idx == pre_len(s.req.kind) - 8'h01) begin
                        next_s.tx_st = TX_SYNC;
                        next_s.tx_idx = '0;
                    end
                end
            end
            TX_SYNC: begin
                if (take) begin
                    next_s.tx_byte = (s.tx_idx == '0) ? SYNC_FIRST
                                                      : SYNC_SECOND;
                    next_s.tx_crc = CRC_INIT;
                    if (s.tx_idx == SYNC_LEN - 8'h01) begin
                        next_s.tx_st = TX_BODY;
                        next_s.tx_idx = '0;
                    end
                end
            end
            TX_BODY: begin
                if (take) begin
                    next_s.tx_byte = body_byte(s.req, s.tx_idx);
                    next_s.tx_crc = rphs_crc_byte(s.tx_crc,
                                                  next_s.tx_byte);
                    if (s.tx_idx == body_len(s.req.kind) - 8'h01) begin
                        next_s.tx_idx = '0;
                        if (s.req.kind == PK_LEGACY) begin
                            next_s.tx_st = TX_IDLE;
                            next_s.tx_done = 1'b1;
                            next_s.rx_mode = 1'b1;
                        end else if (s.req.kind == PK_VAR &&
                                     s.req.length != '0) begin
                            next_s.tx_st = TX_PAY;
                        end else begin
                            next_s.tx_st = TX_CRC;
                        end
                    end
                end
            end
            TX_PAY: begin
                // Stalls here while the payload buffer runs dry
                if (take && fifo_valid) begin
                    fifo_pop = 1'b1;
                    next_s.tx_byte = fifo_data;
                    next_s.tx_crc = rphs_crc_byte(s.tx_crc, fifo_data);
                    if (s.tx_idx == s.req.length - 8'h01) begin
                        next_s.tx_st = TX_CRC;
                        next_s.tx_idx = '0;
                    end
                end
            end
            TX_CRC: begin
                if (take) begin
                    next_s.tx_byte = (s.tx_idx == '0) ? s.tx_crc[15:8]
                                                      : s.tx_crc[7:0];
                    if (s.tx_idx == CRC_LEN - 8'h01) begin
                        next_s.tx_st = TX_IDLE;
                        next_s.tx_done = 1'b1;
                        next_s.rx_mode = 1'b1;
                    end
                end
            end
            default: next_s.tx_st = TX_IDLE;
        endcase
        next_s.busy = (next_s.tx_st != TX_IDLE);

        // Parser; a fresh start abandons any packet in progress
        if (rx_start_in) begin
            next_s.rx_st = RX_HDR;
            next_s.rx_kind = rx_kind_in;
            next_s.rx_idx = '0;
            next_s.rx_crc = CRC_INIT;
            next_s.hdr = '0;
        end else if (rx_valid_in) begin
            case (s.rx_st)
                RX_HDR: begin
                    next_s.hdr = {s.hdr[47:0], b};
                    next_s.rx_crc = rphs_crc_byte(s.rx_crc, b);
                    next_s.rx_idx = s.rx_idx + 8'h01;
                    if (s.rx_kind == PK_LEGACY) begin
                        if (s.rx_idx == LEGACY_BODY_LEN - 8'h01) begin
                            next_s.rx_st = RX_IDLE;
                            if (s.hdr[7:0] == ~s.hdr[15:8] &&
                                b == s.hdr[15:8]) begin
                                next_s.leds = led_apply(s.leds, b);
                                next_s.cmd_ok = 1'b1;
                            end else begin
                                next_s.rx_err = 1'b1;
                            end
                        end
                    end else if (s.rx_kind == PK_STATUS) begin
                        if (s.rx_idx == STATUS_BODY_LEN - 8'h01) begin
                            next_s.rx_st = RX_CRC;
                            next_s.rx_idx = '0;
                        end
                    end else begin
                        next_s.rx_len = b;
                        next_s.rx_idx = '0;
                        next_s.rx_st = (b == '0) ? RX_CRC : RX_PAY;
                    end
                end
                RX_PAY: begin
                    next_s.rx_data = b;
                    next_s.rx_data_valid = 1'b1;
                    next_s.rx_crc = rphs_crc_byte(s.rx_crc, b);
                    next_s.rx_idx = s.rx_idx + 8'h01;
                    if (s.rx_idx == s.rx_len - 8'h01) begin
                        next_s.rx_st = RX_CRC;
                        next_s.rx_idx = '0;
                    end
                end
                RX_CRC: begin
                    next_s.rx_idx = s.rx_idx + 8'h01;
                    if (s.rx_idx == '0) begin
                        next_s.crc_hi = b;
                    end else begin
                        next_s.rx_st = RX_IDLE;
                        if ({s.crc_hi, b} != s.rx_crc) begin
                            next_s.rx_err = 1'b1;
                        end else if (s.rx_kind == PK_STATUS) begin
                            next_s.rpt.fob_id = s.hdr[55:24];
                            next_s.rpt.buttons =
                                s.hdr[16 +: BUTTON_BITS];
                            next_s.rpt.count = s.hdr[15:0];
                            next_s.fob_ok = 1'b1;
                        end else begin
                            next_s.var_ok = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign tx_busy_out          = s.busy;
    assign tx_done_out          = s.tx_done;
    assign rx_mode_out          = s.rx_mode;
    assign tx_byte_out          = s.tx_byte;
    assign tx_valid_out         = s.tx_valid;
    assign cmd_ok_out           = s.cmd_ok;
    assign fob_ok_out           = s.fob_ok;
    assign fob_rpt_out          = s.rpt;
    assign var_ok_out           = s.var_ok;
    assign rx_len_out           = s.rx_len;
    assign rx_data_out          = s.rx_data;
    assign rx_data_valid_out    = s.rx_data_valid;
    assign rx_err_out           = s.rx_err;
    assign led_output_zero_out  = s.leds[0];
    assign led_output_one_out   = s.leds[1];
    assign led_output_two_out   = s.leds[2];
    assign led_output_three_out = s.leds[3];
endmodule // rphs_sequencer

/* rphs_sequencer_chk.sv */
// Port checker for the radio packet sequencer
`timescale 1ns/100ps
module rphs_sequencer_chk
    import rphs_pkg::*;
(
    input wire logic                    clock_in,
    input wire logic                    sys_rst_in,
    input wire logic                    ce_in,
    input wire logic                    tx_start_in,
    input wire logic                    tx_ready_in,
    input wire logic                    tx_busy_out,
    input wire logic                    tx_done_out,
    input wire logic                    rx_mode_out,
    input wire logic [7:0]              tx_byte_out,
    input wire logic                    tx_valid_out,
    input wire logic                    cmd_ok_out,
    input wire logic                    fob_ok_out,
    input wire rphs_pkg::rphs_fob_rpt_t fob_rpt_out,
    input wire logic                    var_ok_out,
    input wire logic                    rx_err_out,
    input wire logic                    led_output_zero_out,
    input wire logic                    led_output_one_out,
    input wire logic                    led_output_two_out,
    input wire logic                    led_output_three_out
);
    ////////////////////////////////////////
    // Start acceptance and LED group
    wire       take = ce_in && tx_start_in && !tx_busy_out;
    wire [3:0] leds = {led_output_three_out, led_output_two_out,
                       led_output_one_out, led_output_zero_out};
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // An idle start shows busy, then a preamble byte one edge later
    property p_start;
        take && !tx_valid_out ##1 ce_in |-> tx_busy_out ##1
            tx_valid_out && tx_byte_out == PREAMBLE_BYTE;
    endproperty
    a_start: assert property (p_start) else $error("no preamble");
    property p_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
    endproperty
    a_hold: assert property (p_hold) else $error("byte lost");
    property p_back; tx_done_out |-> rx_mode_out && !tx_busy_out; endproperty
    a_back: assert property (p_back) else $error("no receive");
    property p_rxoff; take |=> !rx_mode_out; endproperty
    a_rxoff: assert property (p_rxoff) else $error("still rx");
    property p_done1; tx_done_out && ce_in |=> !tx_done_out; endproperty
    a_done1: assert property (p_done1) else $error("long done");
    // Reports and LEDs move only with a good packet, past-reset guarded
    property p_fob;
        !fob_ok_out && !$past(sys_rst_in) |-> $stable(fob_rpt_out);
    endproperty
    a_fob: assert property (p_fob) else $error("report moved");
    property p_led; !cmd_ok_out && !$past(sys_rst_in) |-> $stable(leds);
    endproperty
    a_led: assert property (p_led) else $error("leds moved");
    property p_var; var_ok_out |-> !rx_err_out; endproperty
    a_var: assert property (p_var) else $error("ok with error");
    c_cmd: cover property (cmd_ok_out);
    c_fob: cover property (fob_ok_out);
    c_var: cover property (var_ok_out);
endmodule // rphs_sequencer_chk
bind rphs_sequencer rphs_sequencer_chk u_chk (.*);

/* rphs_radio_model.sv */
// Radio side model: stalling byte sink and packet source
`timescale 1ns/100ps
module rphs_radio_model
    import rphs_pkg::*;
(
    input  wire logic            clock_in,
    input  wire logic [7:0]      tx_byte_out,
    input  wire logic            tx_valid_out,
    output logic                 tx_ready_in = 1'b0,
    output logic                 rx_start_in = 1'b0,
    output rphs_pkg::rphs_kind_t rx_kind_in = PK_LEGACY,
    output logic [7:0]           rx_byte_in = 8'h00,
    output logic                 rx_valid_in = 1'b0
);
    logic [7:0] cap[$];
    int         n = 0;
    ////////////////////////////////////////
    // Stall one cycle in three, as a FIFO near full would
    always @(negedge clock_in) begin
        n = n + 1;
        tx_ready_in <= (n % 3 != 0);
    end
    // Keep accepted bytes in order of arrival
    always @(posedge clock_in) begin
        if (tx_valid_out && tx_ready_in) cap.push_back(tx_byte_out);
    end
    // Post-sync bytes, line inverted once released
    task automatic send(input rphs_kind_t k, input logic [7:0] b[$]);
        @(negedge clock_in);
        rx_start_in = 1'b1;
        rx_kind_in = k;
        @(negedge clock_in);
        rx_start_in = 1'b0;
        foreach (b[i]) begin
            rx_valid_in = 1'b1;
            rx_byte_in = b[i];
            @(negedge clock_in);
        end
        rx_valid_in = 1'b0;
        rx_byte_in = ~rx_byte_in;
    endtask
endmodule // rphs_radio_model

/* radio_packet_host_sequencer_test.sv */
// Self-checking bench for the radio packet sequencer
`timescale 1ns/100ps
module radio_packet_host_sequencer_test;
    import rphs_pkg::*;
    logic clock_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1;
    logic tx_start_in = 1'b0, pay_valid_in = 1'b0, tx_ready_in;
    logic rx_start_in, rx_valid_in, tx_busy_out, tx_done_out, rx_mode_out;
    logic pay_ready_out, tx_valid_out, cmd_ok_out, fob_ok_out, var_ok_out;
    logic rx_data_valid_out, rx_err_out, led_output_zero_out;
    logic led_output_one_out, led_output_two_out, led_output_three_out;
    logic [7:0]    pay_data_in = 8'h00, tx_byte_out, rx_byte_in;
    logic [7:0]    rx_len_out, rx_data_out;
    rphs_tx_req_t  tx_req_in = '0;
    rphs_kind_t    rx_kind_in;
    rphs_fob_rpt_t fob_rpt_out;
    int            err_count = 0, checked = 0;
    logic [15:0]   rx_seen = '0;
    ////////////////////////////////////////
    // Five-byte preamble exercises the long end of the range
    rphs_sequencer #(.VAR_PREAMBLE_BYTES(8'h05)) DUT (.*);
    rphs_radio_model radio (.*);
    // Free-running 100 MHz clock
    always #5 clock_in = ~clock_in;
    // Payload pulses, newest byte low
    always @(posedge clock_in) begin
        if (rx_data_valid_out) rx_seen <= {rx_seen[7:0], rx_data_out};
    end
    task automatic chk(input logic [15:0] a, e, input string m);
        checked++;
        if (a !== e) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    function automatic void crc16(ref logic [7:0] q[$]);
        logic [15:0] r;
        r = 16'hffff;
        foreach (q[k]) for (int i = 7; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ q[k][i]) ? 16'h8005 : 16'h0);
        q = {q, r[15:8], r[7:0]};
    endfunction
    function automatic void hdr(ref logic [7:0] q[$], input int n);
        q = {};
        repeat (n) q.push_back(PREAMBLE_BYTE);
        q = {q, SYNC_FIRST, SYNC_SECOND};
    endfunction
    // Start a frame, let the stalling sink take it, compare every byte
    task automatic run_tx(input rphs_tx_req_t rq, input logic [7:0] e[$]);
        radio.cap = {};
        @(negedge clock_in);
        tx_req_in = rq;
        tx_start_in = 1'b1;
        @(negedge clock_in);
        tx_start_in = 1'b0;
        repeat (300) begin
            @(negedge clock_in);
            if (radio.cap.size() >= e.size() && !tx_busy_out) break;
        end
        chk(16'(rx_mode_out), 16'h1, "not back in receive");
        chk(16'(radio.cap.size()), 16'(e.size()), "frame length");
        foreach (e[i]) chk(16'(radio.cap[i]), 16'(e[i]), "tx byte");
    endtask
    task automatic t_tx_fixed();
        logic [7:0] e[$], b[$];
        hdr(e, 4);
        run_tx('{kind: PK_LEGACY, cmd: 8'h9c, default: '0},
               {e, 8'h9c, 8'h63, 8'h9c});
        b = '{8'h12, 8'h34, 8'h56, 8'h78, 8'he5, 8'hff, 8'h01};
        crc16(b);
        hdr(e, 13);
        run_tx('{kind: PK_STATUS, fob_id: 32'h12345678, status: 8'he5,
                 count: 16'hff01, default: '0},
               {e, b});
        $display("fixed frames sent");
    endtask
    // Push eight bytes into the payload FIFO, check it then refuses, then drain it in one frame
    task automatic t_tx_var();
        logic [7:0] e[$], b[$];
        b = '{8'h08};
        pay_valid_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            pay_data_in = 8'h80 | 8'(i);
            b.push_back(pay_data_in);
            @(negedge clock_in);
        end
        pay_valid_in = 1'b0;
        chk(16'(pay_ready_out), 16'h0, "full FIFO accepts");
        crc16(b);
        hdr(e, 5);
        run_tx('{kind: PK_VAR, length: 8'h08, default: '0},
               {e, b});
        chk(16'(pay_ready_out), 16'h1, "FIFO not drained");
        $display("variable frame sent");
    endtask
    // Good command, then a mismatched copy that must be ignored
    task automatic t_rx_legacy();
        radio.send(PK_LEGACY, '{8'h92, 8'h6d, 8'h92});
        chk(16'(cmd_ok_out), 16'h1, "command refused");
        chk(16'({led_output_three_out, led_output_two_out, led_output_one_out,
                 led_output_zero_out}), 16'h9, "led levels");
        radio.send(PK_LEGACY, '{8'h55, 8'haa, 8'h54});
        chk(16'(rx_err_out), 16'h1, "bad copy accepted");
        chk(16'(led_output_three_out), 16'h1, "led changed");
        $display("legacy receive done");
    endtask
    task automatic t_rx_crc();
        logic [7:0] b[$];
        b = '{8'hca, 8'hfe, 8'h00, 8'h01, 8'he5, 8'h12, 8'h34};
        crc16(b);
        radio.send(PK_STATUS, b);
        chk(16'(fob_ok_out), 16'h1, "status refused");
        chk(16'(fob_rpt_out.buttons), 16'h05, "buttons");
        chk(fob_rpt_out.fob_id[31:16], 16'hcafe, "id");
        chk(fob_rpt_out.count, 16'h1234, "count");
        b = '{8'h02, 8'h41, 8'h42};
        crc16(b);
        radio.send(PK_VAR, b);
        chk(16'(var_ok_out), 16'h1, "var refused");
        chk(16'(rx_len_out), 16'h2, "length");
        chk(rx_seen, 16'h4142, "payload bytes");
        b[4] ^= 8'h01;
        radio.send(PK_VAR, b);
        chk(16'(rx_err_out), 16'h1, "bad CRC accepted");
        $display("checked receive done");
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge clock_in);
        sys_rst_in = 1'b0;
        t_tx_fixed();
        t_tx_var();
        t_rx_legacy();
        t_rx_crc();
        report_and_stop();
    end
    // Watchdog, well past the 130 or so cycles the run needs
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule // radio_packet_host_sequencer_test
